/* File: rtl/servo_io_signal_allocation.sv */
// Purpose: routes drive functions onto inputs and output pin pairs
// Assumes: APB slave, zero wait states; inputs synchronous to mclk
// Notes: allocation and takeover apply on restart; filter immediately
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module servo_io_signal_allocation #(
   parameter int N_IN = 8,
   parameter int CYCLE_CLKS = sioa_pkg::CTRL_CYCLE_CLKS
) (
   input wire logic mclk, // 125 MHz clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [3:0] pstrb, // apb byte strobes
   output logic pready, // apb ready
   output logic [31:0] prdata, // apb read data
   output logic pslverr, // apb error, unmapped address
   input wire logic [N_IN-1:0] pinIn, // physical input levels
   input wire logic [13:0] statusA, // axis A status functions by code
   input wire logic [13:0] statusB, // axis B status functions by code
   output logic [1:0] outPinA, // axis A output pin pairs
   output logic [1:0] outPinB, // axis B output pin pairs
   output logic [26:0] funcIn // input functions by code
);
   // software-side registers
   logic [31:0] inAllocLow;
   logic [31:0] inAllocHigh;
   logic [15:0] outFuncSel;
   logic [3:0] takeoverLow;
   logic [3:0] takeoverHigh;
   logic [9:0] filterCycles;
   logic [N_IN-1:0] busInput;
   logic applyNow;
   // active copies loaded at restart
   logic [7:0] actInAlloc [N_IN];
   logic [15:0] actOutSel;
   logic [N_IN-1:0] actTakeover;
   // control cycle divider
   logic [15:0] divCnt;
   logic ctrlTick;
   // bus decode
   logic wrEn;
   logic rdEn;
   logic mapped;
   logic [31:0] next_prdata;
   logic [N_IN-1:0] rawIn;

   sioa_filt_if #(.N_IN(N_IN)) fio ();

   // byte-lane merge for a write
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // pick one status function; codes above D give low
   function automatic logic pick(input logic [13:0] st,
                                 input logic [3:0] code);
      logic r;
      r = 1'b0;
      if (code <= sioa_pkg::OUT_CODE_MAX) begin
         r = st[code];
      end
      return r;
   endfunction : pick

   // saturate a filter setting at its top value
   function automatic logic [9:0] clampFilt(input logic [15:0] v);
      logic [9:0] r;
      r = v[9:0];
      if (v > {6'h00, sioa_pkg::FILTER_MAX}) begin
         r = sioa_pkg::FILTER_MAX;
      end
      return r;
   endfunction : clampFilt

   assign wrEn = psel && penable && pready && pwrite;
   assign rdEn = psel && !penable && !pwrite;

   // address decode
   always_comb begin
      mapped = 1'b1;
      next_prdata = 32'h00000000;
      case (paddr)
         sioa_pkg::OFS_IN_ALLOC_LOW: next_prdata = inAllocLow;
         sioa_pkg::OFS_IN_ALLOC_HIGH: next_prdata = inAllocHigh;
         sioa_pkg::OFS_OUT_FUNC_SEL: next_prdata = {16'h0000, outFuncSel};
         sioa_pkg::OFS_TAKEOVER_LOW: next_prdata = {28'h0000000, takeoverLow};
         sioa_pkg::OFS_TAKEOVER_HIGH:
            next_prdata = {28'h0000000, takeoverHigh};
         sioa_pkg::OFS_FILTER_CYCLES:
            next_prdata = {22'h000000, filterCycles};
         sioa_pkg::OFS_BUS_INPUT: next_prdata[N_IN-1:0] = busInput;
         sioa_pkg::OFS_RESTART: next_prdata = 32'h00000000;
         sioa_pkg::OFS_STATUS:
            next_prdata = {16'h0000, actTakeover, fio.filtered};
         default: mapped = 1'b0;
      endcase
   end

   // apb answer: ready in the access phase, no wait states
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (rdEn) begin
            prdata <= next_prdata;
         end else if (!psel) begin
            prdata <= 32'h00000000;
         end
      end
   end

   // input allocation fields
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         inAllocLow <= sioa_pkg::RST_IN_ALLOC_LOW;
         inAllocHigh <= sioa_pkg::RST_IN_ALLOC_HIGH;
      end else if (wrEn && paddr == sioa_pkg::OFS_IN_ALLOC_LOW) begin
         inAllocLow <= merge(inAllocLow, pwdata, pstrb);
      end else if (wrEn && paddr == sioa_pkg::OFS_IN_ALLOC_HIGH) begin
         inAllocHigh <= merge(inAllocHigh, pwdata, pstrb);
      end
   end

   // output allocation and takeover masks
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         outFuncSel <= sioa_pkg::RST_OUT_FUNC_SEL;
         takeoverLow <= sioa_pkg::RST_TAKEOVER;
         takeoverHigh <= sioa_pkg::RST_TAKEOVER;
      end else if (wrEn) begin
         if (paddr == sioa_pkg::OFS_OUT_FUNC_SEL) begin
            outFuncSel <= 16'(merge({16'h0000, outFuncSel}, pwdata,
                                    pstrb));
         end
         if (paddr == sioa_pkg::OFS_TAKEOVER_LOW && pstrb[0]) begin
            takeoverLow <= pwdata[3:0];
         end
         if (paddr == sioa_pkg::OFS_TAKEOVER_HIGH && pstrb[0]) begin
            takeoverHigh <= pwdata[3:0];
         end
      end
   end

   // filter setting, live without restart
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         filterCycles <= sioa_pkg::RST_FILTER_CYCLES;
      end else if (wrEn && paddr == sioa_pkg::OFS_FILTER_CYCLES) begin
         filterCycles <= clampFilt(16'(merge({22'h000000, filterCycles},
                                             pwdata, pstrb)));
      end
   end

   // contact values written by the bus master
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         busInput <= '0;
      end else if (wrEn && paddr == sioa_pkg::OFS_BUS_INPUT && pstrb[0]) begin
         busInput <= pwdata[N_IN-1:0];
      end
   end

   // restart strobe, one cycle
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         applyNow <= 1'b0;
      end else begin
         applyNow <= wrEn && paddr == sioa_pkg::OFS_RESTART &&
                     pwdata[sioa_pkg::RESTART_BIT];
      end
   end

   // active allocation copies, loaded only at restart
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int i = 0; i < N_IN; i++) begin
            if (i < 4) begin
               actInAlloc[i] <= sioa_pkg::RST_IN_ALLOC_LOW[(i%4)*8 +: 8];
            end else begin
               actInAlloc[i] <= sioa_pkg::RST_IN_ALLOC_HIGH[(i%4)*8 +: 8];
            end
         end
         actOutSel <= sioa_pkg::RST_OUT_FUNC_SEL;
         actTakeover <= '0;
      end else if (applyNow) begin
         for (int i = 0; i < N_IN; i++) begin
            if (i < 4) begin
               actInAlloc[i] <= inAllocLow[(i%4)*8 +: 8];
            end else begin
               actInAlloc[i] <= inAllocHigh[(i%4)*8 +: 8];
            end
         end
         actOutSel <= outFuncSel;
         actTakeover <= {takeoverHigh, takeoverLow};
      end
   end

   // control cycle tick
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         divCnt <= 16'h0000;
         ctrlTick <= 1'b0;
      end else if (divCnt == 16'(CYCLE_CLKS - 1)) begin
         divCnt <= 16'h0000;
         ctrlTick <= 1'b1;
      end else begin
         divCnt <= divCnt + 16'h0001;
         ctrlTick <= 1'b0;
      end
   end

   // choose bus value or pin level per input
   always_comb begin
      for (int i = 0; i < N_IN; i++) begin
         rawIn[i] = actTakeover[i] ? busInput[i] : pinIn[i];
      end
   end

   assign fio.raw = rawIn;
   assign fio.cycles = filterCycles;
   assign fio.tick = ctrlTick;

   sioa_input_filter #(.N_IN(N_IN)) sioa_input_filter_i (
      .mclk(mclk),
      .rst_n(rst_n),
      .fio(fio)
   );

   // filtered inputs onto their allocated functions
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         funcIn <= '0;
      end else begin
         for (int c = 0; c < sioa_pkg::N_IN_FUNC; c++) begin
            funcIn[c] <= 1'b0;
            for (int i = 0; i < N_IN; i++) begin
               if (actInAlloc[i] == 8'(c) && fio.filtered[i]) begin
                  funcIn[c] <= 1'b1;
               end
            end
         end
      end
   end

   // status functions onto output pin pairs
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         outPinA <= 2'h0;
         outPinB <= 2'h0;
      end else begin
         outPinA[0] <= pick(statusA,
                            actOutSel[sioa_pkg::OUT_A0_LSB +: 4]);
         outPinB[0] <= pick(statusB,
                            actOutSel[sioa_pkg::OUT_B0_LSB +: 4]);
         outPinA[1] <= pick(statusA,
                            actOutSel[sioa_pkg::OUT_A1_LSB +: 4]);
         outPinB[1] <= pick(statusB,
                            actOutSel[sioa_pkg::OUT_B1_LSB +: 4]);
      end
   end

   // axis A first pair follows servo ready when code 2 is selected
   out_a_map_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $past(actOutSel[3:0]) == sioa_pkg::OUT_SERVO_READY |->
      outPinA[0] == $past(statusA[2]))
      else $error("axis A pin pair 0 not servo ready");
   // axis B first pair follows code D
   out_b_map_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $past(actOutSel[11:8]) == 4'hd |->
      outPinB[0] == $past(statusB[13]))
      else $error("axis B pin pair 0 not software overtravel");
   // second pair code 0 is position done
   out_second_map_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $past(actOutSel[7:4]) == 4'h0 |->
      outPinA[1] == $past(statusA[0]))
      else $error("axis A pin pair 1 mismatch");
   // active output selection moves only at restart
   cfg_restart_only_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && !$past(applyNow) |-> $stable(actOutSel) &&
      $stable(actTakeover))
      else $error("active allocation changed without restart");
   // taken-over low input uses bus value
   takeover_low_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      actTakeover[0] |-> fio.raw[0] == busInput[0])
      else $error("low takeover ignored");
   // taken-over high input uses bus value, else pin
   takeover_high_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      fio.raw[4] == (actTakeover[4] ? busInput[4] : pinIn[4]))
      else $error("high takeover source wrong");
   // filter setting stays within range
   filter_range_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      filterCycles <= sioa_pkg::FILTER_MAX)
      else $error("filter setting above range");
   // fifth input reaches its allocated function
   in_fifth_map_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $past(fio.filtered[4]) &&
      $past(actInAlloc[4]) <= sioa_pkg::IN_CODE_MAX |->
      funcIn[$past(actInAlloc[4][4:0])])
      else $error("fifth input function not raised");
   // sixth input reaches its allocated function
   in_sixth_map_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $past(fio.filtered[5]) &&
      $past(actInAlloc[5]) <= sioa_pkg::IN_CODE_MAX |->
      funcIn[$past(actInAlloc[5][4:0])])
      else $error("sixth input function not raised");
   // apb answers in the access phase
   apb_ready_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      psel && !penable |=> pready)
      else $error("apb ready late");
endmodule : servo_io_signal_allocation

/* File: rtl/sioa_pkg.sv */
// Purpose: constants shared by the servo I/O signal allocation block
// Assumes: APB register window, 32-bit data, byte addresses
// Notes: all offsets, configuration reset values, and output codes 0, 1, 2, D and input codes 0 to 4 live here
package sioa_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_IN_ALLOC_LOW = 8'h00;
   localparam logic [7:0] OFS_IN_ALLOC_HIGH = 8'h04;
   localparam logic [7:0] OFS_OUT_FUNC_SEL = 8'h08;
   localparam logic [7:0] OFS_TAKEOVER_LOW = 8'h0c;
   localparam logic [7:0] OFS_TAKEOVER_HIGH = 8'h10;
   localparam logic [7:0] OFS_FILTER_CYCLES = 8'h14;
   localparam logic [7:0] OFS_BUS_INPUT = 8'h18;
   localparam logic [7:0] OFS_RESTART = 8'h1c;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   // reset values
   localparam logic [31:0] RST_IN_ALLOC_LOW = 32'h03020100;
   localparam logic [31:0] RST_IN_ALLOC_HIGH = 32'h07060504;
   localparam logic [15:0] RST_OUT_FUNC_SEL = 16'h0000;
   localparam logic [3:0] RST_TAKEOVER = 4'h0;
   localparam logic [9:0] RST_FILTER_CYCLES = 10'h001;
   // limits
   localparam logic [9:0] FILTER_MAX = 10'h3e8;
   localparam logic [7:0] IN_CODE_MAX = 8'h1a;
   localparam logic [3:0] OUT_CODE_MAX = 4'hd;
   localparam int N_IN_FUNC = 27;
   localparam int N_OUT_FUNC = 14;
   // field positions
   localparam int OUT_A0_LSB = 0;
   localparam int OUT_A1_LSB = 4;
   localparam int OUT_B0_LSB = 8;
   localparam int OUT_B1_LSB = 12;
   localparam int RESTART_BIT = 0;
   // output function codes
   localparam logic [3:0] OUT_POSITION_DONE_OR_SPEED_MATCH = 4'h0;
   localparam logic [3:0] OUT_ROTATION_DETECT_FLAG = 4'h1;
   localparam logic [3:0] OUT_SERVO_READY = 4'h2;
   localparam logic [3:0] OUT_SOFTWARE_OVERTRAVEL_FLAG = 4'hd;
   // input function codes
   localparam logic [7:0] IN_SERVO_ON = 8'h00;
   localparam logic [7:0] IN_PROPORTIONAL_CONTROL = 8'h01;
   localparam logic [7:0] IN_FORWARD_OVERTRAVEL = 8'h02;
   localparam logic [7:0] IN_REVERSE_OVERTRAVEL = 8'h03;
   localparam logic [7:0] IN_ALARM_RESET = 8'h04;
   // control cycle length in mclk cycles
   localparam int CTRL_CYCLE_CLKS = 125;
endpackage : sioa_pkg

/* File: rtl/sioa_filt_if.sv */
// Purpose: carrier between the allocation core and the input filter
// Assumes: single clock domain
// Notes: the core drives raw levels, setting and tick
`timescale 1ns/1ps
interface sioa_filt_if #(parameter int N_IN = 8);
   logic [N_IN-1:0] raw;
   logic [9:0] cycles;
   logic tick;
   logic [N_IN-1:0] filtered;
   modport filt (input raw, input cycles, input tick, output filtered);
   modport core (output raw, output cycles, output tick, input filtered);
endinterface : sioa_filt_if

/* File: rtl/sioa_input_filter.sv */
// Purpose: per-input level filter counted in control cycles
// Assumes: tick is a one-cycle pulse per control cycle
// Notes: a level must differ for cycles ticks before it passes
`timescale 1ns/1ps
module sioa_input_filter #(
   parameter int N_IN = 8
) (
   input wire logic mclk, // system clock
   input wire logic rst_n, // synchronous reset, active low
   sioa_filt_if.filt fio // raw in, filtered out
);
   logic [9:0] cnt [N_IN];

   // count ticks while raw differs; setting read live
   always_ff @(posedge mclk) begin
      for (int i = 0; i < N_IN; i++) begin
         if (!rst_n) begin
            cnt[i] <= 10'h000;
            fio.filtered[i] <= 1'b0;
         end else if (fio.raw[i] == fio.filtered[i]) begin
            cnt[i] <= 10'h000;
         end else if (fio.cycles == 10'h000) begin
            fio.filtered[i] <= fio.raw[i];
         end else if (fio.tick) begin
            if (cnt[i] + 10'h001 >= fio.cycles) begin
               fio.filtered[i] <= fio.raw[i];
               cnt[i] <= 10'h000;
            end else begin
               cnt[i] <= cnt[i] + 10'h001;
            end
         end
      end
   end

   // zero setting passes levels on the next edge
   filt_zero_pass_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      fio.cycles == 10'h000 |=> fio.filtered == $past(fio.raw))
      else $error("zero filter did not pass input");
   // a filtered change needs a tick unless setting is zero
   filt_change_tick_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      $past(rst_n) && $changed(fio.filtered) |->
      $past(fio.tick) || $past(fio.cycles) == 10'h000)
      else $error("filtered input changed without a control tick");
endmodule : sioa_input_filter

/* File: verif/sioa_field_model.sv */
// Purpose: field side model that drives input pins and axis status lines
// Assumes: one clock; levels change only just after a rising edge
// Notes: requested levels reach the pins one edge later, like a sensor
`timescale 1ns/1ps
module sioa_field_model (
   input wire logic mclk, // system clock
   input wire logic [7:0] wantPins, // requested pin levels
   input wire logic [13:0] wantA, // requested axis A status
   input wire logic [13:0] wantB, // requested axis B status
   output logic [7:0] pinIn, // physical input levels
   output logic [13:0] statusA, // axis A status lines
   output logic [13:0] statusB // axis B status lines
);
   // registered so pin edges never land on the block's sampling edge
   always_ff @(posedge mclk) begin
      pinIn <= wantPins;
      statusA <= wantA;
      statusB <= wantB;
   end
endmodule : sioa_field_model

/* File: verif/test_servo_io_signal_allocation.sv */
// Purpose: self-checking bench for the servo I/O signal allocation block
// Assumes: zero-wait APB slave, control cycle shortened to 4 clocks
// Notes: each scenario is a task that drives and judges on its own
`timescale 1ns/1ps
module test_servo_io_signal_allocation;
   localparam int CYC = 4;
   logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr, pinIn, wantPins;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [13:0] statusA, statusB, wantA, wantB;
   logic [1:0] outPinA, outPinB;
   logic [26:0] funcIn;
   int errCount, checkCount;

   // device under test with a short control cycle
   servo_io_signal_allocation #(.N_IN(8), .CYCLE_CLKS(CYC))
      servo_io_signal_allocation_i (.mclk(mclk), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .pinIn(pinIn), .statusA(statusA),
      .statusB(statusB), .outPinA(outPinA), .outPinB(outPinB),
      .funcIn(funcIn));

   // far side: pins and axis status
   sioa_field_model sioa_field_model_i (.mclk(mclk), .wantPins(wantPins),
      .wantA(wantA), .wantB(wantB), .pinIn(pinIn), .statusA(statusA),
      .statusB(statusB));

   // 125 MHz clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // verdict and end of run
   task automatic endSim();
      $display("checks %0d mismatches %0d", checkCount, errCount);
      if (errCount == 0 && checkCount > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : endSim

   // compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         errCount++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic clks(input int n);
      repeat (n) @(posedge mclk);
   endtask : clks

   // one apb transfer; pready and read data are taken at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      // request held until an edge sees pready high
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         errCount++;
         endSim();
      end else begin
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   task automatic restart();
      apb(1'b1, sioa_pkg::OFS_RESTART, 32'h1);
      clks(4);
   endtask : restart

   // counts clocks until a function line reaches a level
   task automatic waitFunc(input int idx, input logic lvl, output int n);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (funcIn[idx] !== lvl && n < 200);
      if (funcIn[idx] !== lvl) begin
         errCount++;
         endSim();
      end
   endtask : waitFunc

   // reset values and an unmapped address
   task automatic testRegs();
      apb(1'b0, sioa_pkg::OFS_IN_ALLOC_LOW, 0);
      check(rd, 32'h03020100);
      apb(1'b0, sioa_pkg::OFS_IN_ALLOC_HIGH, 0);
      check(rd, 32'h07060504);
      apb(1'b0, sioa_pkg::OFS_OUT_FUNC_SEL, 0);
      check(rd, 32'h0);
      apb(1'b0, sioa_pkg::OFS_TAKEOVER_LOW, 0);
      check(rd, 32'h0);
      apb(1'b0, sioa_pkg::OFS_TAKEOVER_HIGH, 0);
      check(rd, 32'h0);
      apb(1'b0, sioa_pkg::OFS_FILTER_CYCLES, 0);
      check(rd, 32'h1);
      apb(1'b0, 8'h24, 0);
      check({31'h0, er}, 32'h1);
      check(rd, 32'h0);
   endtask : testRegs

   // every output code on every pin pair, then a mixed selection
   task automatic testOutputs();
      apb(1'b1, sioa_pkg::OFS_OUT_FUNC_SEL, 32'h2222);
      wantA <= 14'h0004;
      wantB <= 14'h0004;
      clks(4);
      check({outPinB, outPinA}, 32'h0);
      for (int c = 0; c <= 14; c++) begin
         apb(1'b1, sioa_pkg::OFS_OUT_FUNC_SEL, {16'h0, {4{c[3:0]}}});
         restart();
         wantA <= (c < 14) ? 14'h1 << c : 14'h3fff;
         wantB <= (c < 14) ? 14'h1 << c : 14'h3fff;
         clks(4);
         check({outPinB, outPinA}, (c < 14) ? 32'hf : 32'h0);
         wantA <= (c < 14) ? ~(14'h1 << c) : 14'h0;
         wantB <= (c < 14) ? ~(14'h1 << c) : 14'h0;
         clks(4);
         check({outPinB, outPinA}, 32'h0);
      end
      apb(1'b1, sioa_pkg::OFS_OUT_FUNC_SEL, 32'hd20d);
      apb(1'b0, sioa_pkg::OFS_OUT_FUNC_SEL, 0);
      check(rd, 32'hd20d);
      restart();
      wantA <= 14'h2000;
      wantB <= 14'h2000;
      clks(4);
      check({outPinB, outPinA}, 32'h9);
   endtask : testOutputs

   // filter delay at zero and at three cycles, and saturation
   task automatic testFilter();
      int n;
      apb(1'b1, sioa_pkg::OFS_FILTER_CYCLES, 32'h0);
      wantPins <= 8'h10;
      waitFunc(4, 1'b1, n);
      // pin model, filter and function stages, seen at the next negedge
      check(n, 4);
      apb(1'b1, sioa_pkg::OFS_FILTER_CYCLES, 32'h3);
      wantPins <= 8'h00;
      waitFunc(4, 1'b0, n);
      // three ticks of differing level plus the same three stages
      check(n >= 3 * CYC && n <= 3 * CYC + 3, 1);
      apb(1'b1, sioa_pkg::OFS_FILTER_CYCLES, 32'h7d0);
      apb(1'b0, sioa_pkg::OFS_FILTER_CYCLES, 0);
      check(rd, 32'h3e8);
      apb(1'b1, sioa_pkg::OFS_FILTER_CYCLES, 32'h0);
   endtask : testFilter

   // bus master takes inputs 1 and 6; applies only after restart
   task automatic testTakeover();
      apb(1'b1, sioa_pkg::OFS_BUS_INPUT, 32'h21);
      apb(1'b1, sioa_pkg::OFS_TAKEOVER_LOW, 32'h1);
      apb(1'b1, sioa_pkg::OFS_TAKEOVER_HIGH, 32'h2);
      clks(4);
      check({5'h0, funcIn}, 32'h0);
      restart();
      clks(2);
      check({5'h0, funcIn}, 32'h21);
      apb(1'b0, sioa_pkg::OFS_STATUS, 0);
      check({24'h0, rd[15:8]}, 32'h21);
      wantPins <= 8'h10;
      clks(6);
      check({5'h0, funcIn}, 32'h31);
      apb(1'b1, sioa_pkg::OFS_TAKEOVER_LOW, 32'h0);
      apb(1'b1, sioa_pkg::OFS_TAKEOVER_HIGH, 32'h0);
      restart();
   endtask : testTakeover

   // input 5 to the top code, input 6 to code zero
   task automatic testInputs();
      apb(1'b1, sioa_pkg::OFS_IN_ALLOC_HIGH, 32'h0706001a);
      restart();
      wantPins <= 8'h10;
      clks(6);
      check({5'h0, funcIn}, 32'h4000000);
      wantPins <= 8'h20;
      clks(6);
      check({5'h0, funcIn}, 32'h1);
      wantPins <= 8'h08;
      clks(6);
      check({5'h0, funcIn}, 32'h8);
   endtask : testInputs

   // main sequence
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hf;
      wantPins = 8'h00;
      wantA = 14'h0;
      wantB = 14'h0;
      errCount = 0;
      checkCount = 0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      testRegs();
      testOutputs();
      testFilter();
      testTakeover();
      testInputs();
      endSim();
   end
endmodule : test_servo_io_signal_allocation
